/* common/nvmwc_pkg.sv */
// Purpose: Shared constants and types for the nonvolatile memory write control block
// Assumes: Registers sit in the low byte of aligned 32-bit Avalon-MM words
// Notes: Byte offsets are compared against {address, 2'b00}
package nvmwc_pkg;

   // Register byte offsets
   localparam logic [4:0] OFF_CONTROL = 5'h00;
   localparam logic [4:0] OFF_UNLOCK = 5'h04;
   localparam logic [4:0] OFF_ADDR_LO = 5'h08;
   localparam logic [4:0] OFF_ADDR_HI = 5'h0C;
   localparam logic [4:0] OFF_DATA = 5'h10;
   localparam logic [4:0] OFF_STATUS = 5'h14;

   // Unlock key bytes
   localparam logic [7:0] UNLOCK_FIRST = 8'h55;
   localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

   // Region select codes; bit 0 set means configuration space
   localparam logic [1:0] REGION_DATA = 2'h0;
   localparam logic [1:0] REGION_PFM = 2'h2;
   localparam int unsigned REGION_CFG_BIT = 0;

   // First address beyond the data memory
   localparam logic [15:0] DATA_MEM_TOP = 16'h0400;

   // Status register field
   localparam int unsigned STATUS_DONE_BIT = 0;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [31:0] RDATA_RESET = 32'h00000000;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_READ,
      OP_EE_WRITE,
      OP_PFM_WRITE,
      OP_PFM_ERASE,
      OP_CFG_WRITE
   } nvmwc_op_e;

   // Control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic [1:0] region;
      logic rsv;
      logic free;
      logic write_error_flag;
      logic wen;
      logic wr;
      logic rd;
   } nvmwc_ctrl_s;

   // One-cycle command to the memory array
   typedef struct packed {
      nvmwc_op_e op;
      logic [1:0] region;
      logic [15:0] addr;
      logic [7:0] wdata;
   } nvmwc_mem_cmd_s;

endpackage : nvmwc_pkg

/* design/nvmwc_top.sv */
// Purpose: Control, unlock and error logic for byte-wide nonvolatile memory access
// Assumes: All non-clock inputs come from logic on clk_i; memory returns read data in the cycle of
//          a read command and pulses mem_done_i when a write ends
// Notes: nrst_i is the power-on reset; sys_rst_n_i is a later synchronous reset

// Operation
// - Outside programming reads and writes refused while data code protect is on
// - Start on protected or invalid address clears start and sets error flag
// - Write-enable bit is zero after power-up
// - No write may start while the power-up timer runs
// - Region 00 data memory, 10 program flash, x1 configuration space
// - Erase-select one makes next program flash start an erase
// - Reset during a running write sets the error flag
// - Data region start with address at or above 0x0400 sets error flag
// - Only software clears the error flag
// - Software may write the error flag to one
// - Write-enable zero inhibits all program, erase and refresh cycles
// - Data region start launches combined erase and program of one byte
// - Program flash start launches write from holding registers
// - Write start needs 0x55 then 0xAA to the unlock register first
// - Operations self-timed; hardware clears start bit at the end
// - Writing zero to start bit during a write has no effect
// - Read start outside program flash region loads the data register and clears itself
// - Software may set read start but never clear it
// - Unlock register always reads zero
// - Low address register holds address bits 7 to 0
// - Write end clears start and sets the done flag, cleared by software
// - Read data ready for the very next bus access
// - One write setting both start and write-enable starts nothing
// - Control, address and data registers frozen while a write runs
module nvmwc_top (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic sys_rst_n_i,
   input wire logic pwrt_active_i,
   input wire logic data_cp_i,
   input wire logic data_wp_i,
   input wire logic addr_invalid_i,
   input wire logic ext_rd_req_i,
   input wire logic ext_wr_req_i,
   output logic ext_rd_grant_o,
   output logic ext_wr_grant_o,
   input wire logic [2:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   output nvmwc_pkg::nvmwc_mem_cmd_s mem_cmd_o,
   input wire logic [7:0] mem_rdata_i,
   input wire logic mem_done_i,
   output logic write_allow_o,
   output logic done_flag_o
);

   typedef enum logic [1:0] {
      UNL_IDLE,
      UNL_HALF,
      UNL_ARMED
   } nvmwc_unl_e;

   nvmwc_pkg::nvmwc_ctrl_s ctrl_q;
   nvmwc_pkg::nvmwc_ctrl_s wctrl;
   nvmwc_unl_e unl_q;
   logic [15:0] addr_q;
   logic [7:0] data_q;
   logic accept;
   logic wr_acc;
   logic ctrl_wr;
   logic start_try;
   logic bad_target;
   logic mismatch;
   logic wr_launch;
   logic wr_reject;
   logic rd_launch;
   logic [4:0] byte_addr;

   function automatic logic addr_in_data(input logic [15:0] a);
      addr_in_data = a < nvmwc_pkg::DATA_MEM_TOP;
   endfunction : addr_in_data

   function automatic nvmwc_pkg::nvmwc_op_e op_for(input logic [1:0] region, input logic free);
      if (region[nvmwc_pkg::REGION_CFG_BIT])
         op_for = nvmwc_pkg::OP_CFG_WRITE;
      else if (region == nvmwc_pkg::REGION_PFM)
         op_for = free ? nvmwc_pkg::OP_PFM_ERASE : nvmwc_pkg::OP_PFM_WRITE;
      else
         op_for = nvmwc_pkg::OP_EE_WRITE;
   endfunction : op_for

   assign byte_addr = {address_i, 2'b00};
   assign accept = (read_i | write_i) & ~waitrequest_o;
   assign wr_acc = accept & write_i & byteenable_i[0];
   assign wctrl = nvmwc_pkg::nvmwc_ctrl_s'(writedata_i[7:0]);
   assign ctrl_wr = wr_acc & (byte_addr == nvmwc_pkg::OFF_CONTROL) & ~ctrl_q.wr;

   // Start attempt: key armed, enable already set, timer done
   assign start_try = ctrl_wr & wctrl.wr & (unl_q == UNL_ARMED)
      & ctrl_q.wen
      & ~pwrt_active_i;
   assign mismatch = (wctrl.region == nvmwc_pkg::REGION_DATA) & ~addr_in_data(addr_q);
   assign bad_target = mismatch | addr_invalid_i
      | (data_wp_i & (wctrl.region == nvmwc_pkg::REGION_DATA));
   assign wr_launch = start_try & ~bad_target;
   assign wr_reject = start_try & bad_target;
   assign rd_launch = ctrl_wr & wctrl.rd & ~ctrl_q.rd & ~wr_launch
      & (wctrl.region != nvmwc_pkg::REGION_PFM);

   // Control register
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ctrl_q <= nvmwc_pkg::CTRL_RESET;
      end
      else if (!sys_rst_n_i)
      begin
         ctrl_q <= nvmwc_pkg::CTRL_RESET;
         ctrl_q.write_error_flag <= ctrl_q.write_error_flag | ctrl_q.wr;
      end
      else
      begin
         if (ctrl_wr)
         begin
            ctrl_q.region <= wctrl.region;
            ctrl_q.free <= wctrl.free;
            ctrl_q.wen <= wctrl.wen;
         end
         // Hardware set wins over a software write
         if (wr_reject)
            ctrl_q.write_error_flag <= 1'b1;
         else if (ctrl_wr)
            ctrl_q.write_error_flag <= wctrl.write_error_flag;
         if (wr_launch)
            ctrl_q.wr <= 1'b1;
         else if (mem_done_i)
            ctrl_q.wr <= 1'b0;
         if (rd_launch)
            ctrl_q.rd <= 1'b1;
         else if (ctrl_q.rd)
            ctrl_q.rd <= 1'b0;
      end
   end

   // Unlock sequencer; any other access disarms
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         unl_q <= UNL_IDLE;
      else if (!sys_rst_n_i)
         unl_q <= UNL_IDLE;
      else if (accept)
      begin
         if (wr_acc && byte_addr == nvmwc_pkg::OFF_UNLOCK
             && writedata_i[7:0] == nvmwc_pkg::UNLOCK_FIRST)
            unl_q <= UNL_HALF;
         else if (wr_acc && byte_addr == nvmwc_pkg::OFF_UNLOCK && unl_q == UNL_HALF
                  && writedata_i[7:0] == nvmwc_pkg::UNLOCK_SECOND)
            unl_q <= UNL_ARMED;
         else
            unl_q <= UNL_IDLE;
      end
   end

   // Address register pair
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         addr_q <= nvmwc_pkg::ADDR_RESET;
      else if (wr_acc && !ctrl_q.wr)
      begin
         if (byte_addr == nvmwc_pkg::OFF_ADDR_LO)
            addr_q[7:0] <= writedata_i[7:0];
         if (byte_addr == nvmwc_pkg::OFF_ADDR_HI)
            addr_q[15:8] <= writedata_i[7:0];
      end
   end

   // Data register: bus write or read result
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         data_q <= nvmwc_pkg::DATA_RESET;
      else if (ctrl_q.rd)
         data_q <= mem_rdata_i;
      else if (wr_acc && !ctrl_q.wr && byte_addr == nvmwc_pkg::OFF_DATA)
         data_q <= writedata_i[7:0];
   end

   // Done flag; set wins over a software clear
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         done_flag_o <= 1'b0;
      else if (ctrl_q.wr && mem_done_i && sys_rst_n_i)
         done_flag_o <= 1'b1;
      else if (wr_acc && byte_addr == nvmwc_pkg::OFF_STATUS
               && !writedata_i[nvmwc_pkg::STATUS_DONE_BIT])
         done_flag_o <= 1'b0;
   end

   // Memory command, one cycle per launch
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         mem_cmd_o.op <= nvmwc_pkg::OP_NONE;
         mem_cmd_o.region <= nvmwc_pkg::REGION_DATA;
         mem_cmd_o.addr <= nvmwc_pkg::ADDR_RESET;
         mem_cmd_o.wdata <= nvmwc_pkg::DATA_RESET;
      end
      else
      begin
         mem_cmd_o.region <= wctrl.region;
         mem_cmd_o.addr <= addr_q;
         mem_cmd_o.wdata <= data_q;
         if (wr_launch)
            mem_cmd_o.op <= op_for(wctrl.region, wctrl.free);
         else if (rd_launch)
            mem_cmd_o.op <= nvmwc_pkg::OP_READ;
         else
            mem_cmd_o.op <= nvmwc_pkg::OP_NONE;
      end
   end

   // Array-level program/erase/refresh permission
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         write_allow_o <= 1'b0;
      else
         write_allow_o <= ctrl_q.wen & ~pwrt_active_i;
   end

   // Outside programming access gate
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ext_rd_grant_o <= 1'b0;
         ext_wr_grant_o <= 1'b0;
      end
      else
      begin
         ext_rd_grant_o <= ext_rd_req_i & ~data_cp_i;
         ext_wr_grant_o <= ext_wr_req_i & ~data_cp_i;
      end
   end

   // Avalon slave: one wait cycle, held off while a read is pending
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         waitrequest_o <= 1'b1;
      else if (waitrequest_o && (read_i || write_i) && !ctrl_q.rd)
         waitrequest_o <= 1'b0;
      else
         waitrequest_o <= 1'b1;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         readdata_o <= nvmwc_pkg::RDATA_RESET;
      else if (waitrequest_o && read_i && !ctrl_q.rd)
      begin
         unique case (byte_addr)
            nvmwc_pkg::OFF_CONTROL: readdata_o <= {24'h000000, ctrl_q};
            nvmwc_pkg::OFF_ADDR_LO: readdata_o <= {24'h000000, addr_q[7:0]};
            nvmwc_pkg::OFF_ADDR_HI: readdata_o <= {24'h000000, addr_q[15:8]};
            nvmwc_pkg::OFF_DATA: readdata_o <= {24'h000000, data_q};
            nvmwc_pkg::OFF_STATUS: readdata_o <= {31'h00000000, done_flag_o};
            default: readdata_o <= nvmwc_pkg::RDATA_RESET;
         endcase
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);

   unlock_gate_a: assert property ($rose(ctrl_q.wr) |-> $past(unl_q) == UNL_ARMED)
      else $error("write started without unlock");
   enable_gate_a: assert property ($rose(ctrl_q.wr) |-> $past(ctrl_q.wen))
      else $error("write started without prior enable");
   timer_block_a: assert property ($rose(ctrl_q.wr) |-> !$past(pwrt_active_i))
      else $error("write started during power-up timer");
   reject_flag_a: assert property (wr_reject |=> ctrl_q.write_error_flag && !ctrl_q.wr)
      else $error("rejected start not flagged");
   reset_error_a: assert property (!sys_rst_n_i && ctrl_q.wr |=> ctrl_q.write_error_flag)
      else $error("reset during write not flagged");
   error_hold_a: assert property ($fell(ctrl_q.write_error_flag) |-> $past(ctrl_wr && !wctrl.write_error_flag))
      else $error("error flag cleared without software");
   unlock_zero_a: assert property (!waitrequest_o && read_i
      && byte_addr == nvmwc_pkg::OFF_UNLOCK |-> readdata_o == 32'h00000000)
      else $error("unlock register read nonzero");
   read_path_a: assert property (rd_launch
      |=> mem_cmd_o.op == nvmwc_pkg::OP_READ && ctrl_q.rd
      ##1 !ctrl_q.rd && data_q == $past(mem_rdata_i))
      else $error("read did not load data in time");
   busy_freeze_a: assert property (ctrl_q.wr && sys_rst_n_i
      |=> $stable(addr_q) && $stable(data_q) && $stable(ctrl_q.region))
      else $error("registers changed during write");
   write_end_a: assert property (ctrl_q.wr && mem_done_i && sys_rst_n_i
      |=> !ctrl_q.wr && done_flag_o)
      else $error("write end not handled");
   start_hold_a: assert property (ctrl_q.wr && !mem_done_i && sys_rst_n_i |=> ctrl_q.wr)
      else $error("write start bit dropped early");
   op_select_a: assert property (wr_launch
      |=> mem_cmd_o.op == $past(op_for(wctrl.region, wctrl.free)))
      else $error("wrong memory operation");
   ext_guard_a: assert property (data_cp_i |=> !ext_rd_grant_o && !ext_wr_grant_o)
      else $error("outside access granted under protect");

   launch_c: cover property (wr_launch ##[1:50] mem_done_i);
   reject_c: cover property (wr_reject);
   read_c: cover property (rd_launch);
   reset_hit_c: cover property (ctrl_q.wr && !sys_rst_n_i);

endmodule : nvmwc_top

/* bench/nvmwc_mem_model.sv */
// Purpose: Behavioural memory array behind the write control block
// Assumes: One-cycle commands on cmd_i, clock shared with the block
// Notes: Write and erase complete DELAY cycles after the command
module nvmwc_mem_model #(
   parameter int DELAY = 20
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire nvmwc_pkg::nvmwc_mem_cmd_s cmd_i,
   output logic [7:0] rdata_o,
   output logic done_o
);
   logic [7:0] mem_q [1024];
   logic [7:0] last_q;
   logic hold_q;
   int cnt_q;
   // Valid in command cycle and the next, inverted junk afterwards
   assign rdata_o = (cmd_i.op == nvmwc_pkg::OP_READ) ? mem_q[cmd_i.addr[9:0]] :
      (hold_q ? last_q : ~last_q);
   always @(posedge clk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         cnt_q <= 0;
         done_o <= 1'b0;
         hold_q <= 1'b0;
         last_q <= 8'h00;
      end
      else
      begin
         done_o <= 1'b0;
         hold_q <= (cmd_i.op == nvmwc_pkg::OP_READ);
         if (cmd_i.op == nvmwc_pkg::OP_READ)
            last_q <= mem_q[cmd_i.addr[9:0]];
         if (cmd_i.op == nvmwc_pkg::OP_EE_WRITE)
            mem_q[cmd_i.addr[9:0]] <= cmd_i.wdata;
         if (cmd_i.op != nvmwc_pkg::OP_NONE && cmd_i.op != nvmwc_pkg::OP_READ)
            cnt_q <= DELAY;
         else if (cnt_q > 0)
         begin
            cnt_q <= cnt_q - 1;
            done_o <= (cnt_q == 1);
         end
      end
endmodule : nvmwc_mem_model

/* bench/nvm_eeprom_write_control_test.sv */
// Purpose: Self-checking register-level bench for nvmwc_top
// Assumes: Memory model answers mem_cmd_o
// Notes: Tests are sequences of Avalon-MM accesses
module nvm_eeprom_write_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [4:0] R_CTL = nvmwc_pkg::OFF_CONTROL;
   localparam logic [4:0] R_KEY = nvmwc_pkg::OFF_UNLOCK;
   localparam logic [4:0] R_ALO = nvmwc_pkg::OFF_ADDR_LO;
   localparam logic [4:0] R_STS = nvmwc_pkg::OFF_STATUS;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic sys_rst_n_i = 1'b1;
   logic pwrt_active_i = 1'b0;
   logic data_cp_i = 1'b0;
   logic data_wp_i = 1'b0;
   logic addr_invalid_i = 1'b0;
   logic ext_rd_req_i = 1'b0;
   logic ext_wr_req_i = 1'b0;
   logic ext_rd_grant_o, ext_wr_grant_o, waitrequest_o;
   logic [2:0] address_i = 3'h0;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [31:0] writedata_i = 32'h00000000;
   logic [3:0] byteenable_i = 4'hF;
   logic [31:0] readdata_o, q;
   nvmwc_pkg::nvmwc_mem_cmd_s mem_cmd_o;
   logic [7:0] mem_rdata_i;
   logic mem_done_i, write_allow_o, done_flag_o;
   logic [2:0] last_op = 3'h0;
   int error_cnt = 0;
   int tests_run = 0;
   logic [7:0] ctab [4] = '{8'h86, 8'h96, 8'h46, 8'hC6};
   nvmwc_pkg::nvmwc_op_e otab [4] = '{nvmwc_pkg::OP_PFM_WRITE, nvmwc_pkg::OP_PFM_ERASE,
      nvmwc_pkg::OP_CFG_WRITE, nvmwc_pkg::OP_CFG_WRITE};
   nvmwc_top i_nvmwc_top (.clk_i, .nrst_i, .sys_rst_n_i, .pwrt_active_i, .data_cp_i,
      .data_wp_i, .addr_invalid_i, .ext_rd_req_i, .ext_wr_req_i, .ext_rd_grant_o,
      .ext_wr_grant_o, .address_i, .read_i, .write_i, .writedata_i, .byteenable_i,
      .readdata_o, .waitrequest_o, .mem_cmd_o, .mem_rdata_i, .mem_done_i, .write_allow_o,
      .done_flag_o);
   nvmwc_mem_model i_nvmwc_mem_model (.clk_i, .nrst_i, .cmd_i(mem_cmd_o),
      .rdata_o(mem_rdata_i), .done_o(mem_done_i));
   initial
      forever #12.5 clk_i = ~clk_i;
   always @(posedge clk_i)
      if (mem_cmd_o.op != nvmwc_pkg::OP_NONE)
         last_op <= mem_cmd_o.op;
   task automatic finish_test;
      if (error_cnt == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   task automatic bus(input logic wr, input logic [4:0] off, input logic [7:0] d);
      address_i <= off[4:2];
      writedata_i <= {24'h000000, d};
      write_i <= wr;
      read_i <= !wr;
      // Waits for the slave however long it takes; only the watchdog ends a hang
      do
         @(posedge clk_i);
      while (waitrequest_o !== 1'b0);
      q = readdata_o;
      write_i <= 1'b0;
      read_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rc(input logic [4:0] off, input logic [7:0] exp);
      bus(1'b0, off, 8'h00);
      chk(q, {24'h000000, exp});
   endtask : rc
   task automatic go(input logic [7:0] ctrl);
      bus(1'b1, R_KEY, nvmwc_pkg::UNLOCK_FIRST);
      bus(1'b1, R_KEY, nvmwc_pkg::UNLOCK_SECOND);
      bus(1'b1, R_CTL, ctrl);
   endtask : go
   task automatic wait_idle;
      int n;
      n = 0;
      do
      begin
         bus(1'b0, R_CTL, 8'h00);
         n++;
      end while (q[1] !== 1'b0 && n < 40);
   endtask : wait_idle
   initial
   begin
      #200us;
      error_cnt++;
      finish_test();
   end
   initial
   begin
      repeat (5) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      rc(R_CTL, 8'h00);
      rc(R_ALO, 8'h00);
      rc(5'h1C, 8'h00);
      bus(1'b1, R_ALO, 8'h05);
      rc(R_ALO, 8'h05);
      byteenable_i <= 4'hE;
      bus(1'b1, R_ALO, 8'h77);
      byteenable_i <= 4'hF;
      rc(R_ALO, 8'h05);
      bus(1'b1, nvmwc_pkg::OFF_DATA, 8'h3C);
      bus(1'b1, R_KEY, 8'h55);
      rc(R_KEY, 8'h00);
      go(8'h02);
      rc(R_CTL, 8'h00);
      go(8'h06);
      rc(R_CTL, 8'h04);
      pwrt_active_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({31'h0, write_allow_o}, 32'h0);
      go(8'h06);
      rc(R_CTL, 8'h04);
      pwrt_active_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({31'h0, write_allow_o}, 32'h1);
      bus(1'b1, R_KEY, 8'h55);
      bus(1'b0, R_ALO, 8'h00);
      bus(1'b1, R_KEY, 8'hAA);
      bus(1'b1, R_CTL, 8'h06);
      rc(R_CTL, 8'h04);
      go(8'h06);
      rc(R_CTL, 8'h06);
      bus(1'b1, R_CTL, 8'h04);
      bus(1'b1, R_ALO, 8'h09);
      rc(R_CTL, 8'h06);
      rc(R_ALO, 8'h05);
      wait_idle();
      rc(R_CTL, 8'h04);
      chk({29'h0, last_op}, {29'h0, nvmwc_pkg::OP_EE_WRITE});
      chk({24'h0, i_nvmwc_mem_model.mem_q[5]}, 32'h3C);
      rc(R_STS, 8'h01);
      bus(1'b1, R_STS, 8'h00);
      rc(R_STS, 8'h00);
      bus(1'b1, R_CTL, 8'h05);
      rc(nvmwc_pkg::OFF_DATA, 8'h3C);
      rc(R_CTL, 8'h04);
      data_wp_i <= 1'b1;
      go(8'h06);
      rc(R_CTL, 8'h0C);
      chk({29'h0, last_op}, {29'h0, nvmwc_pkg::OP_READ});
      data_wp_i <= 1'b0;
      bus(1'b1, R_CTL, 8'h04);
      rc(R_CTL, 8'h04);
      addr_invalid_i <= 1'b1;
      go(8'h06);
      rc(R_CTL, 8'h0C);
      addr_invalid_i <= 1'b0;
      bus(1'b1, R_CTL, 8'h0C);
      rc(R_CTL, 8'h0C);
      bus(1'b1, R_CTL, 8'h04);
      bus(1'b1, nvmwc_pkg::OFF_ADDR_HI, 8'h04);
      go(8'h06);
      rc(R_CTL, 8'h0C);
      bus(1'b1, R_CTL, 8'h85);
      rc(R_CTL, 8'h84);
      for (int i = 0; i < 4; i++)
      begin
         go(ctab[i]);
         wait_idle();
         chk({29'h0, last_op}, {29'h0, otab[i]});
      end
      bus(1'b1, nvmwc_pkg::OFF_ADDR_HI, 8'h00);
      bus(1'b1, R_CTL, 8'h04);
      go(8'h06);
      sys_rst_n_i <= 1'b0;
      @(posedge clk_i);
      sys_rst_n_i <= 1'b1;
      @(posedge clk_i);
      rc(R_CTL, 8'h08);
      repeat (30) @(posedge clk_i);
      ext_rd_req_i <= 1'b1;
      ext_wr_req_i <= 1'b1;
      data_cp_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      chk({30'h0, ext_rd_grant_o, ext_wr_grant_o}, 32'h0);
      data_cp_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({30'h0, ext_rd_grant_o, ext_wr_grant_o}, 32'h3);
      finish_test();
   end
endmodule : nvm_eeprom_write_control_test
